// >>> design/sio_pkg.sv
// Shared constants and types of the synchronous serial shifter.
package sio_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int BYTE_W = 8;

  // Register addresses as seen on the plain register port.
  localparam logic [11:0] ADDR_TRIGGER = 12'h2e7;
  localparam logic [11:0] ADDR_PORT_R = 12'h2ec;
  localparam logic [11:0] ADDR_DATA_LO = 12'h2f0;
  localparam logic [11:0] ADDR_DATA_HI = 12'h2f1;
  localparam logic [11:0] ADDR_CTRL = 12'h2f2;
  localparam logic [11:0] ADDR_FLAG = 12'h2f3;

  // Field positions.
  localparam int TRIG_BIT = 3;
  localparam int GP_BIT = 1;
  localparam int FLAG_BIT = 0;

  // Clock mode encodings.
  localparam logic [1:0] MODE_CLK = 2'h0;
  localparam logic [1:0] MODE_CLK2 = 2'h1;
  localparam logic [1:0] MODE_CLK4 = 2'h2;
  localparam logic [1:0] MODE_SLAVE = 2'h3;

  // Half periods of the generated serial clock, in system clock cycles.
  localparam int DIV_W = 3;
  localparam logic [2:0] HALF_CLK = 3'h1;
  localparam logic [2:0] HALF_CLK2 = 3'h2;
  localparam logic [2:0] HALF_CLK4 = 3'h4;

  // Serial clock cycles per transfer.
  localparam logic [3:0] XFER_CYCLES = 4'h8;

  // Reset values.
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic RST_GP = 1'b0;

  typedef struct packed {
    logic clk_mode_sel_hi;
    logic clk_mode_sel_lo;
    logic sample_edge_sel;
    logic xfer_irq_enable;
  } serial_control_type;

  localparam serial_control_type RST_CTRL = 4'hc;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_type;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } xfer_state_type;

  function automatic logic [2:0] half_cycles(input logic [1:0] mode);
    case (mode)
      MODE_CLK: half_cycles = HALF_CLK;
      MODE_CLK2: half_cycles = HALF_CLK2;
      default: half_cycles = HALF_CLK4;
    endcase
  endfunction

endpackage

// >>> design/sclk_divider.sv
// Tick generator that paces the master-mode serial clock edges.
`timescale 1ns/1ps
module sclk_divider
  import sio_pkg::*;
#(
  parameter int CNT_W = DIV_W
) (
  // System side
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [CNT_W-1:0] half,
  // Pace
  output logic tick
);

  generate
    if (CNT_W < 3) begin : g_chk
      $error("sclk_divider needs at least 3 counter bits");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic hit;

  assign hit = run && (cnt_r == half - {{(CNT_W-1){1'b0}}, 1'b1});
  assign tick = hit;

  // The counter is held at zero while stopped so each transfer starts with a full half period.
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run || hit) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// >>> design/edge_detect_sync.sv
// Two-stage synchroniser with edge detection for a pin from outside the clock domain.
`timescale 1ns/1ps
module edge_detect_sync
  import sio_pkg::*;
#(
  parameter bit INVERT = 1'b0
) (
  // System side
  input wire logic clock,
  input wire logic rst_n,
  // Pin
  input wire logic pin,
  // Synchronised level and its edges
  output edge_type edges
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;
  logic sync_nxt;
  logic prev_nxt;
  logic lvl;
  logic lvl_prev;

  // Only the second stage and its delayed copy feed the edge logic.
  assign lvl = sync_r ^ INVERT;
  assign lvl_prev = prev_r ^ INVERT;
  assign edges = {lvl, lvl && !lvl_prev, !lvl && lvl_prev};

  always_comb begin
    meta_nxt = pin;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // The stages reset to the pin's idle level, so no false edge follows reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INVERT;
      sync_r <= INVERT;
      prev_r <= INVERT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

endmodule

// >>> design/sync_serial_8bit_shifter.sv
// Clocked 8-bit synchronous serial interface with master and slave clocking.
//
// Behaviour
// - Two-bit clock mode: system clock, half, quarter as master; 11 means slave.
// - Reset selects slave mode with the external clock.
// - Master drives the serial clock pin; slave shifts on the external clock.
// - Master stops after eight pulses and holds the clock low.
// - Slave ignores further clock pulses after eight until the next trigger.
// - Writing 1 to the trigger bit starts shifting out the loaded byte.
// - Serial output changes on the rising serial clock edge.
// - Edge select: 1 samples input on rising edge, 0 on falling edge.
// - Eight counted serial clock cycles complete the transfer and set the flag.
// - Flag sets regardless of mask; request forwarded only when enabled.
// - Sampled bits shift in and are readable through the two data halves.
// - One shared 8-bit register transmits and receives in the same cycles.
// - Bit order for both directions is a build-time parameter.
// - Availability rises at the trigger write and falls after eight cycles.
// - A general output bit may be replaced by the availability output.
// - Serial clock pin polarity is a build-time option.
// - Do not switch the system clock source while a transfer runs.
// - Read received data only while the interface is halted.
// - Reading the done flag returns it and clears it at once.
`timescale 1ns/1ps
module sync_serial_8bit_shifter
  import sio_pkg::*;
#(
  parameter bit LSB_FIRST = 1'b1,
  parameter bit INVERT_SCLK = 1'b0,
  parameter bit AVAIL_ON_GP = 1'b1
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Serial data pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Serial clock pin, two-way
  input wire logic sclk_pin_in,
  output logic sclk_pin_out,
  output logic sclk_pin_oe,
  // Status and request
  output logic xfer_available_out,
  output logic gp_out_bit_one,
  output logic xfer_irq
);

  generate
    if (BYTE_W != 8 || DATA_W != 4) begin : g_chk
      $error("sync_serial_8bit_shifter supports only an 8-bit byte in two 4-bit halves");
    end
  endgenerate

  xfer_state_type state_r;
  xfer_state_type state_nxt;
  serial_control_type ctrl_r;
  serial_control_type ctrl_nxt;
  logic [BYTE_W-1:0] shift_r;
  logic [BYTE_W-1:0] shift_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic sclk_gen_r;
  logic sclk_gen_nxt;
  logic serial_out_pin_r;
  logic serial_out_pin_nxt;
  logic busy_r;
  logic busy_nxt;
  logic flag_r;
  logic flag_nxt;
  logic gp_r;
  logic gp_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  logic [1:0] mode;
  logic master;
  logic running;
  logic tick;
  logic rise;
  logic fall;
  logic sample_rise;
  logic sin_lvl;
  edge_type sclk_edges;
  edge_type sin_edges;

  function automatic logic [BYTE_W-1:0] shift_in(input logic [BYTE_W-1:0] cur,
                                                 input logic bit_in);
    if (LSB_FIRST) begin
      shift_in = {bit_in, cur[BYTE_W-1:1]};
    end else begin
      shift_in = {cur[BYTE_W-2:0], bit_in};
    end
  endfunction

  function automatic logic out_bit(input logic [BYTE_W-1:0] cur);
    out_bit = LSB_FIRST ? cur[0] : cur[BYTE_W-1];
  endfunction

  assign mode = {ctrl_r.clk_mode_sel_hi, ctrl_r.clk_mode_sel_lo};
  assign master = (mode != MODE_SLAVE);
  assign running = (state_r == ST_RUN);
  assign sample_rise = ctrl_r.sample_edge_sel;

  // The divider runs only during a master transfer, so the pin cannot toggle while idle.
  sclk_divider #(
    .CNT_W(DIV_W)
  ) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .run(running && master),
    .half(half_cycles(mode)),
    .tick(tick)
  );

  // The external clock pin is sampled like any pin; inversion undoes the pin polarity option.
  edge_detect_sync #(
    .INVERT(INVERT_SCLK)
  ) u_sclk_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(sclk_pin_in),
    .edges(sclk_edges)
  );

  // Data input passes the same two stages so it stays aligned with the clock edges.
  edge_detect_sync #(
    .INVERT(1'b0)
  ) u_sin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(serial_in_pin),
    .edges(sin_edges)
  );

  assign sin_lvl = sin_edges.level;

  // Edges are only acted on during a transfer; once eight are counted the slave clock is masked.
  always_comb begin
    rise = 1'b0;
    fall = 1'b0;
    if (running) begin
      if (master) begin
        rise = tick && !sclk_gen_r;
        fall = tick && sclk_gen_r;
      end else begin
        rise = sclk_edges.rise;
        fall = sclk_edges.fall;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    sclk_gen_nxt = sclk_gen_r;
    serial_out_pin_nxt = serial_out_pin_r;
    busy_nxt = busy_r;
    flag_nxt = flag_r;
    gp_nxt = gp_r;
    rdata_nxt = '0;

    if (reg_rd) begin
      case (reg_addr)
        ADDR_DATA_LO: rdata_nxt = shift_r[3:0];
        ADDR_DATA_HI: rdata_nxt = shift_r[7:4];
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_FLAG: begin
          rdata_nxt[FLAG_BIT] = flag_r;
          flag_nxt = 1'b0;
        end
        ADDR_PORT_R: rdata_nxt[GP_BIT] = AVAIL_ON_GP ? busy_r : gp_r;
        default: rdata_nxt = '0;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        ADDR_DATA_LO: shift_nxt[3:0] = reg_wdata;
        ADDR_DATA_HI: shift_nxt[7:4] = reg_wdata;
        ADDR_CTRL: ctrl_nxt = reg_wdata;
        ADDR_PORT_R: gp_nxt = reg_wdata[GP_BIT];
        ADDR_TRIGGER: begin
          if (reg_wdata[TRIG_BIT] && !running) begin
            state_nxt = ST_RUN;
            cnt_nxt = '0;
            busy_nxt = 1'b1;
            sclk_gen_nxt = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (running) begin
      if (master && tick) begin
        sclk_gen_nxt = !sclk_gen_r;
      end
      // The sampling serial edge outranks a software write to the data halves in the same cycle.
      if (rise) begin
        serial_out_pin_nxt = out_bit(shift_r);
        if (sample_rise) begin
          shift_nxt = shift_in(shift_r, sin_lvl);
        end
      end
      if (fall) begin
        if (!sample_rise) begin
          shift_nxt = shift_in(shift_r, sin_lvl);
        end
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == XFER_CYCLES - 4'h1) begin
          state_nxt = ST_IDLE;
          sclk_gen_nxt = 1'b0;
          busy_nxt = 1'b0;
          flag_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ctrl_r <= RST_CTRL;
      shift_r <= RST_SHIFT;
      cnt_r <= '0;
      sclk_gen_r <= 1'b0;
      serial_out_pin_r <= 1'b0;
      busy_r <= 1'b0;
      flag_r <= 1'b0;
      gp_r <= RST_GP;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      sclk_gen_r <= sclk_gen_nxt;
      serial_out_pin_r <= serial_out_pin_nxt;
      busy_r <= busy_nxt;
      flag_r <= flag_nxt;
      gp_r <= gp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Switching the system clock source mid-transfer would stretch the generated clock.
  assign sclk_pin_oe = master;
  assign sclk_pin_out = master ? (sclk_gen_r ^ INVERT_SCLK) : 1'b0;
  assign serial_out_pin = serial_out_pin_r;
  assign reg_rdata = rdata_r;
  assign xfer_available_out = busy_r;
  assign gp_out_bit_one = AVAIL_ON_GP ? busy_r : gp_r;
  assign xfer_irq = flag_r && ctrl_r.xfer_irq_enable;

endmodule

// >>> verification/shifter_sva.sv
// Port-level assertions for the serial shifter.
`timescale 1ns/1ps
module shifter_sva
  import sio_pkg::*;
#(
  parameter bit INVERT_SCLK = 1'b0,
  parameter bit AVAIL_ON_GP = 1'b1
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Pins
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic sclk_pin_in,
  input wire logic sclk_pin_out,
  input wire logic sclk_pin_oe,
  input wire logic xfer_available_out,
  input wire logic gp_out_bit_one,
  input wire logic xfer_irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] mode_r;
  logic [3:0] rises_r;
  // The mode lives inside the block, so it is shadowed from control writes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_SLAVE;
      rises_r <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        mode_r <= reg_wdata[3:2];
      end
      if ($rose(xfer_available_out)) begin
        rises_r <= 4'h0;
      end else if ($rose(sclk_pin_out)) begin
        rises_r <= rises_r + 4'h1;
      end
    end
  end
  sequence flag_read;
    reg_rd && reg_addr == ADDR_FLAG && !xfer_available_out;
  endsequence
  sequence trigger_write;
    reg_wr && reg_addr == ADDR_TRIGGER && reg_wdata[TRIG_BIT] && !xfer_available_out;
  endsequence
  AST_AVAIL_RISE: assert property (trigger_write |=> xfer_available_out)
    else $error("availability did not rise after trigger");
  AST_FLAG_CLEAR: assert property (
    flag_read ##1 !xfer_available_out ##1 flag_read |=> reg_rdata[FLAG_BIT] == 1'b0)
    else $error("done flag not cleared by read");
  AST_IRQ_CAUSE: assert property (
    $rose(xfer_irq) |-> $fell(xfer_available_out) || $past(reg_wr && reg_addr == ADDR_CTRL))
    else $error("request rose without completion or enable");
  AST_PULSE_COUNT: assert property (
    sclk_pin_oe && $fell(xfer_available_out) |-> rises_r == 4'h8)
    else $error("master pulse count wrong at completion");
  AST_CLOCK_IDLE: assert property (
    sclk_pin_oe && !xfer_available_out |-> sclk_pin_out == INVERT_SCLK)
    else $error("master clock not idle low");
  AST_OE_MODE: assert property (sclk_pin_oe == (mode_r != MODE_SLAVE))
    else $error("clock pin drive does not follow mode");
  AST_HALF_CLK: assert property (
    sclk_pin_oe && mode_r == MODE_CLK && $rose(sclk_pin_out) |=> $fell(sclk_pin_out))
    else $error("full-rate half period wrong");
  AST_HALF_CLK4: assert property (
    sclk_pin_oe && mode_r == MODE_CLK4 && $rose(sclk_pin_out)
    |=> sclk_pin_out [*3] ##1 $fell(sclk_pin_out))
    else $error("quarter-rate half period wrong");
  AST_SERIAL_OUT_PIN_EDGE: assert property (
    sclk_pin_oe && $changed(serial_out_pin) |-> $rose(sclk_pin_out))
    else $error("serial output changed off the rising clock");
  AST_GP_AVAIL: assert property (AVAIL_ON_GP |-> gp_out_bit_one == xfer_available_out)
    else $error("port bit does not carry availability");
endmodule

bind sync_serial_8bit_shifter shifter_sva #(.INVERT_SCLK(INVERT_SCLK), .AVAIL_ON_GP(AVAIL_ON_GP))
  u_sva (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_in_pin,
  .serial_out_pin, .sclk_pin_in, .sclk_pin_out, .sclk_pin_oe, .xfer_available_out,
  .gp_out_bit_one, .xfer_irq);

// >>> verification/far_end.sv
// Far-side serial device: clocks the link as master or answers as slave.
`timescale 1ns/1ps
module far_end (
  // Bench control
  input wire logic arm,
  input wire logic [3:0] pulses,
  input wire logic sample_rise,
  input wire logic [7:0] tx_byte,
  // Link
  input wire logic sclk,
  input wire logic avail,
  input wire logic dev_serial_out_pin,
  output logic sclk_drive,
  output logic sin_drive,
  output logic busy,
  output logic [7:0] rx_byte
);
  int rises;
  int falls;
  initial begin
    sclk_drive = 1'b0;
    busy = 1'b0;
    rx_byte = 8'h00;
  end
  always @(posedge arm) begin
    rises = 0;
    falls = 0;
    if (pulses != 4'h0) begin
      busy = 1'b1;
      wait (avail);
      // The offset keeps every pin change away from the system clock edges.
      #106;
      for (int k = 0; k < pulses; k++) begin
        sclk_drive = 1'b1;
        #100 sclk_drive = 1'b0;
        // Sampled late in the low phase, since the device answers some cycles after an edge.
        #100 if (k < 8) rx_byte = {dev_serial_out_pin, rx_byte[7:1]};
      end
      busy = 1'b0;
    end
  end
  always @(posedge sclk) rises++;
  always @(negedge sclk) begin
    if (pulses == 4'h0 && falls < 8) rx_byte = {dev_serial_out_pin, rx_byte[7:1]};
    falls++;
  end
  // New data goes out on the edge opposite to the one the device samples on.
  assign sin_drive = tx_byte[sample_rise ? falls[2:0] : (rises == 0 ? 3'h0 : 3'(rises - 1))];
endmodule

// >>> verification/sync_serial_8bit_shifter_bench.sv
// Self-checking bench of the serial shifter against its far-side partner.
`timescale 1ns/1ps
module sync_serial_8bit_shifter_bench;
  import sio_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, serial_in_pin, serial_out_pin, sclk_pin_out;
  logic sclk_pin_oe, xfer_available_out, gp_out_bit_one, xfer_irq, sclk_drive, sclk_wire;
  logic far_busy, arm, sample_rise;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [3:0] pulses;
  logic [7:0] far_tx, far_rx;
  int errors, check_count;

  assign sclk_wire = sclk_pin_oe ? sclk_pin_out : sclk_drive;
  sync_serial_8bit_shifter u_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .serial_in_pin, .serial_out_pin, .sclk_pin_in(sclk_wire), .sclk_pin_out,
    .sclk_pin_oe, .xfer_available_out, .gp_out_bit_one, .xfer_irq);
  far_end u_far (.arm, .pulses, .sample_rise, .tx_byte(far_tx), .sclk(sclk_wire),
    .avail(xfer_available_out), .dev_serial_out_pin(serial_out_pin), .sclk_drive,
    .sin_drive(serial_in_pin), .busy(far_busy), .rx_byte(far_rx));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [3:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  task automatic xfer(input logic [3:0] ctrl, input logic [3:0] n, input logic [7:0] dev_byte,
    input logic [7:0] far_byte);
    wr(ADDR_CTRL, ctrl);
    wr(ADDR_DATA_LO, dev_byte[3:0]);
    wr(ADDR_DATA_HI, dev_byte[7:4]);
    far_tx <= far_byte;
    pulses <= n;
    sample_rise <= ctrl[1];
    arm <= 1'b1;
    wr(ADDR_TRIGGER, 4'h8);
    arm <= 1'b0;
    @(posedge clock);
    #1;
    chk({7'h0, xfer_available_out}, 8'h01);
    rd(ADDR_PORT_R, 4'h2);
    wr(ADDR_TRIGGER, 4'h8);
    for (int i = 0; i < 400 && xfer_available_out !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h0, xfer_available_out}, 8'h00);
    for (int i = 0; i < 400 && far_busy !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h0, far_busy}, 8'h00);
    chk(far_rx, dev_byte);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A run that hangs is cut off well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, arm, sample_rise} = 5'h00;
    reg_addr = '0;
    reg_wdata = '0;
    pulses = '0;
    far_tx = '0;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({7'h0, sclk_pin_oe}, 8'h00);
    rd(ADDR_CTRL, 4'hc);
    rd(12'h2f5, 4'h0);
    rd(ADDR_PORT_R, 4'h0);
    rd(ADDR_TRIGGER, 4'h0);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      xfer({m[1:0], m[0], 1'b1}, 4'h0, 8'ha5 ^ 8'(m), 8'h6c);
      chk({7'h0, xfer_irq}, 8'h01);
      chk({7'h0, sclk_pin_out}, 8'h00);
      if (m == 2) begin
        rd(ADDR_DATA_LO, 4'hc);
        rd(ADDR_DATA_HI, 4'h6);
      end
      rd(ADDR_FLAG, 4'h1);
      rd(ADDR_FLAG, 4'h0);
      $display("test master mode %0d done", m);
    end
    xfer({MODE_SLAVE, 2'h2}, 4'ha, 8'h3c, 8'h96);
    chk({7'h0, xfer_irq}, 8'h00);
    rd(ADDR_DATA_LO, 4'h6);
    rd(ADDR_DATA_HI, 4'h9);
    wr(ADDR_CTRL, {MODE_SLAVE, 2'h3});
    #1;
    chk({7'h0, xfer_irq}, 8'h01);
    rd(ADDR_FLAG, 4'h1);
    $display("test slave mode done");
    complete_run();
  end
endmodule
